// ### rmlc_consts.svh
`ifndef RMLC_CONSTS_SVH
`define RMLC_CONSTS_SVH
// register indices (printed offsets), byte address is four times the index
`define RMLC_IDX_LOCK      5'h1f
`define RMLC_IDX_FIRST_RW  5'h00
`define RMLC_NUM_MAP       31
// field layout of the protection register
`define RMLC_KEY_HI        23
`define RMLC_KEY_LO        16
`define RMLC_CRC_HI        15
`define RMLC_CRC_LO        0
`define RMLC_KEY_UNLOCK    8'ha5
`define RMLC_CRC_RESET     16'h0000
`define RMLC_MAP_RESET     24'h00_0000
// checksum refresh period, in digital master clock periods
`define RMLC_CRC_PERIOD    25
`define RMLC_CRC_POLY      16'h8005
`define RMLC_CRC_INIT      16'hffff
`define RMLC_UNDEF_READ    32'hdead_beef
`endif

// ### rmlc_pkg.sv
package rmlc_pkg;
  typedef logic [23:0] rmlc_word_t;
  typedef logic [15:0] rmlc_crc_t;
  typedef enum logic [1:0] {RMLC_IDLE, RMLC_RUN, RMLC_DONE} rmlc_crc_state_e;
endpackage : rmlc_pkg

// ### rmlc_crc_byte.sv
`timescale 1ns/1ns
`default_nettype none
`include "rmlc_consts.svh"
module rmlc_crc_byte
  import rmlc_pkg::*;
(
  input  wire logic [15:0] crcIn,
  input  wire logic [7:0]  dataIn,
  output logic      [15:0] crcOut
);
  logic [15:0] stage [0:8];
  assign stage[0] = crcIn;
  // one bit per step, msb first
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      assign stage[b+1] = (stage[b][15] ^ dataIn[7-b]) ?
                          ({stage[b][14:0], 1'b0} ^ `RMLC_CRC_POLY) :
                          {stage[b][14:0], 1'b0};
    end
  endgenerate
  assign crcOut = stage[8];
endmodule : rmlc_crc_byte
`default_nettype wire

// ### rmlc_crc_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "rmlc_consts.svh"
module rmlc_crc_engine
  import rmlc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              enable,
  input  wire rmlc_pkg::rmlc_word_t mapWord,
  input  wire rmlc_pkg::rmlc_word_t mapWordHi,
  output logic      [4:0]        wordIdx,
  output logic                   resultValid,
  output rmlc_pkg::rmlc_crc_t    result
);
  import rmlc_pkg::*;
  rmlc_crc_state_e stateReg, stateNext;
  logic [4:0]  idxReg, idxNext;
  logic [4:0]  tickReg, tickNext;
  logic [15:0] accReg, accNext;
  logic [15:0] c1, c2, c3, c4, c5, c6;
  rmlc_crc_byte uB2 (.crcIn(accReg), .dataIn(mapWord[23:16]), .crcOut(c1));
  rmlc_crc_byte uB1 (.crcIn(c1),     .dataIn(mapWord[15:8]),  .crcOut(c2));
  rmlc_crc_byte uB0 (.crcIn(c2),     .dataIn(mapWord[7:0]),   .crcOut(c3));
  // second word per cycle keeps a full pass inside one refresh period
  rmlc_crc_byte uA2 (.crcIn(c3),     .dataIn(mapWordHi[23:16]), .crcOut(c4));
  rmlc_crc_byte uA1 (.crcIn(c4),     .dataIn(mapWordHi[15:8]),  .crcOut(c5));
  rmlc_crc_byte uA0 (.crcIn(c5),     .dataIn(mapWordHi[7:0]),   .crcOut(c6));
  assign wordIdx = idxReg;
  always_comb begin
    stateNext = stateReg;
    idxNext = idxReg;
    accNext = accReg;
    tickNext = tickReg;
    resultValid = 1'b0;
    if (!enable) begin
      stateNext = RMLC_IDLE; // R5
      tickNext = 5'd0;
    end else begin
      tickNext = (tickReg == 5'(`RMLC_CRC_PERIOD - 1)) ? 5'd0 : tickReg + 5'd1; // R11
      unique case (stateReg)
        RMLC_IDLE: begin
          stateNext = RMLC_RUN;
          idxNext = `RMLC_IDX_FIRST_RW;
          accNext = `RMLC_CRC_INIT; // R12
        end
        RMLC_RUN: begin
          accNext = (idxReg == 5'(`RMLC_NUM_MAP - 1)) ? c3 : c6; // R10
          idxNext = idxReg + 5'd2;
          if (idxReg == 5'(`RMLC_NUM_MAP - 1)) stateNext = RMLC_DONE; // R11
        end
        RMLC_DONE: begin
          if (tickReg == 5'(`RMLC_CRC_PERIOD - 1)) begin
            resultValid = 1'b1; // R11
            stateNext = RMLC_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateReg <= RMLC_IDLE;
      idxReg <= 5'd0;
      accReg <= `RMLC_CRC_INIT;
      tickReg <= 5'd0;
    end else begin
      stateReg <= stateNext;
      idxReg <= idxNext;
      accReg <= accNext;
      tickReg <= tickNext;
    end
  end
  assign result = accReg;
endmodule : rmlc_crc_engine
`default_nettype wire

// ### rmlc_top.sv
// How it works
// R1 - key in bits 23:16, checksum in bits 15:0 of protection register
// R2 - after reset the key holds the unlock value
// R3 - unlock key lets every writable register accept writes
// R4 - unlocked: checksum held at zero, checksum interrupt condition cleared
// R5 - unlocked: no checksum is computed
// R6 - locked: only the protection register accepts writes
// R7 - locked: reads of other registers return undefined contents
// R8 - locked: checksum runs continuously, interrupt only when enabled
// R9 - host writes unlock key before writing other registers while locked
// R10 - checksum is a crc16 over the writable map, read only
// R11 - checksum refreshed every 25 master clock periods
// R12 - polynomial, seed and byte order follow the link crc definition
`timescale 1ns/1ns
`default_nettype none
`include "rmlc_consts.svh"
module rmlc_top
  import rmlc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        crcIntEnable,
  output logic             crcIntFlag,
  output logic             mapLocked
);
  import rmlc_pkg::*;
  rmlc_word_t mapReg [0:`RMLC_NUM_MAP-1];
  rmlc_word_t mapNext [0:`RMLC_NUM_MAP-1];
  logic [7:0]  keyReg, keyNext;
  rmlc_crc_t   map_checksum, crcNext;
  logic        intReg, intNext;
  logic [31:0] rdReg, rdNext;
  logic        errReg, errNext;
  logic        unlocked;
  logic        access;
  logic [4:0]  idx;
  logic        addrOk;
  logic [4:0]  engIdx;
  logic        engValid;
  rmlc_crc_t   engResult;
  rmlc_crc_t   prevCrc;
  logic        respReg, respNext;
  logic        wrEn;
  rmlc_word_t  engWordHi;

  assign unlocked = (keyReg == `RMLC_KEY_UNLOCK);
  assign mapLocked = ~unlocked;
  assign access = psel & penable;
  assign idx = paddr[6:2];
  assign addrOk = (paddr[31:7] == 25'd0) && (paddr[1:0] == 2'b00);
  // one wait state so registered read data stands at the ready edge
  assign pready = access & respReg;
  assign wrEn = access & respReg & pwrite & addrOk;
  assign engWordHi = (engIdx == 5'(`RMLC_NUM_MAP - 1)) ? `RMLC_MAP_RESET : mapReg[engIdx + 5'd1];
  assign prdata = rdReg;
  assign pslverr = errReg;
  assign crcIntFlag = intReg;

  rmlc_crc_engine uEngine (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .enable      (~unlocked), // R5 R8
    .mapWord     (mapReg[engIdx]),
    .mapWordHi   (engWordHi),
    .wordIdx     (engIdx),
    .resultValid (engValid),
    .result      (engResult)
  );

  // data registers of the writable map
  genvar g;
  generate
    for (g = 0; g < `RMLC_NUM_MAP; g++) begin : g_map
      always_comb begin
        mapNext[g] = mapReg[g];
        if (wrEn && unlocked && idx == 5'(g))
          mapNext[g] = pwdata[23:0]; // R3 R6
      end
      always_ff @(posedge ref_clk) begin
        if (rst) mapReg[g] <= `RMLC_MAP_RESET;
        else mapReg[g] <= mapNext[g];
      end
    end
  endgenerate

  // protection register, checksum and interrupt condition
  always_comb begin
    keyNext = keyReg;
    crcNext = map_checksum;
    intNext = intReg;
    if (wrEn && idx == `RMLC_IDX_LOCK)
      keyNext = pwdata[`RMLC_KEY_HI:`RMLC_KEY_LO]; // R1 R6
    if (unlocked) begin
      crcNext = `RMLC_CRC_RESET; // R4
      intNext = 1'b0; // R4
    end else if (engValid) begin
      crcNext = engResult; // R10 R11
      if (crcIntEnable && prevCrc != engResult && prevCrc != `RMLC_CRC_RESET)
        intNext = 1'b1; // R8
    end
  end

  // read data and error answer
  always_comb begin
    rdNext = rdReg;
    errNext = 1'b0;
    respNext = access & ~respReg;
    if (access && !respReg && !addrOk) errNext = 1'b1;
    if (access && !respReg && !pwrite) begin
      if (!addrOk) rdNext = 32'h0000_0000;
      else if (idx == `RMLC_IDX_LOCK)
        rdNext = {8'h00, keyReg, map_checksum}; // R1
      else if (!unlocked) rdNext = `RMLC_UNDEF_READ; // R7
      else rdNext = {8'h00, mapReg[idx]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      keyReg <= `RMLC_KEY_UNLOCK; // R2
      map_checksum <= `RMLC_CRC_RESET;
      intReg <= 1'b0;
      rdReg <= 32'h0000_0000;
      errReg <= 1'b0;
      prevCrc <= `RMLC_CRC_RESET;
      respReg <= 1'b0;
    end else begin
      respReg <= respNext;
      keyReg <= keyNext;
      map_checksum <= crcNext;
      intReg <= intNext;
      rdReg <= rdNext;
      errReg <= errNext;
      prevCrc <= crcNext;
    end
  end
endmodule : rmlc_top
`default_nettype wire

// ### rmlc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rmlc_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        crcIntEnable,
  input wire logic        crcIntFlag,
  input wire logic        mapLocked
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc;
  logic lk;
  assign acc = psel && penable;
  assign lk  = paddr == 32'h0000_007c;
  a_ready_now: assert property (acc && !pready |=> pready) else $error("no ready");
  a_key_open: assert property (
    acc && pready && pwrite && lk && pwdata[23:16] == 8'ha5 |=> !mapLocked)
    else $error("no unlock");
  a_key_close: assert property (
    acc && pready && pwrite && lk && pwdata[23:16] != 8'ha5 |=> mapLocked)
    else $error("no lock");
  a_crc_zero: assert property (
    acc && pready && !pwrite && lk && !mapLocked |-> prdata == 32'h00a5_0000)
    else $error("crc not zero");
  a_undef_read: assert property (
    acc && pready && !pwrite && paddr < 32'h0000_007c && paddr[1:0] == 2'b00 && mapLocked
    |-> prdata == 32'hdead_beef) else $error("locked read defined");
  a_flag_clear: assert property (!mapLocked |=> !crcIntFlag) else $error("flag set");
  a_int_gate: assert property (
    $rose(crcIntFlag) |-> $past(crcIntEnable) && $past(mapLocked)) else $error("int ungated");
  a_bad_addr: assert property (acc && pready && paddr[31:7] != 0 |-> pslverr)
    else $error("no slverr");
  a_ok_addr: assert property (acc && pready && lk |-> !pslverr) else $error("stray slverr");
endmodule : rmlc_checker
`default_nettype wire

// ### rmlc_host.sv
`timescale 1ns/1ns
`default_nettype none
module rmlc_host (
  input wire logic        ref_clk,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic     [31:0] paddr,
  output logic     [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
  end
  // one apb transfer; read data and error taken at the ready edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : rmlc_host
`default_nettype wire

// ### rmlc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rmlc_top_tb;
  logic ref_clk = 1'b0, rst = 1'b1, crcIntEnable = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, crcIntFlag, mapLocked, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  int err_total = 0, num_checks = 0;
  always #50 ref_clk = ~ref_clk;
  rmlc_top u_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .crcIntEnable, .crcIntFlag, .mapLocked);
  rmlc_host u_host (.ref_clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, er);
  endtask : wr
  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0000_0000, rd, er);
    chk(rd, exp);
  endtask : rdchk
  // crc of map with word 0 set, others zero, msb first
  function automatic logic [15:0] crcOf(input logic [23:0] w0);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < 31; i++) begin
      for (int b = 23; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ (i == 0 && w0[b])) ? 16'h8005 : 16'h0000);
      end
    end
    return c;
  endfunction : crcOf
  task s_open;
    rdchk(32'h0000_007c, 32'h00a5_0000);
    chk({31'h0, mapLocked}, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0012_3456);
    rdchk(32'h0000_0000, 32'h0012_3456);
    wr(32'h0000_007c, 32'h00a5_ffff);
    rdchk(32'h0000_007c, 32'h00a5_0000);
  endtask : s_open
  task s_lock;
    crcIntEnable <= 1'b1;
    wr(32'h0000_007c, 32'h003c_0000);
    rdchk(32'h0000_007c, 32'h003c_0000);
    wr(32'h0000_0000, 32'h00ab_cdef);
    rdchk(32'h0000_0000, 32'hdead_beef);
    repeat (60) @(posedge ref_clk);
    rdchk(32'h0000_007c, {16'h003c, crcOf(24'h12_3456)});
    wr(32'h0000_007c, 32'h00a5_0000);
    rdchk(32'h0000_007c, 32'h00a5_0000);
    rdchk(32'h0000_0000, 32'h0012_3456);
    chk({31'h0, crcIntFlag}, 32'h0000_0000);
  endtask : s_lock
  task s_err;
    u_host.xfer(1'b0, 32'h0000_0080, 32'h0000_0000, rd, er);
    chk({31'h0, er}, 32'h0000_0001);
    u_host.xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rd, er);
    chk({31'h0, er}, 32'h0000_0000);
  endtask : s_err
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    s_open;
    s_lock;
    s_err;
    print_verdict;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    print_verdict;
  end
endmodule : rmlc_top_tb
bind rmlc_top rmlc_checker u_chk (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .crcIntEnable, .crcIntFlag, .mapLocked);
`default_nettype wire
